// [irq_ctrl_pkg.sv]
// Package for the system interrupt controller: widths, field positions,
// reset values and the code table shared by the controller and its helper.
// Assumes a single 10 MHz clock domain with a synchronous active-low reset.
package irq_ctrl_pkg;

    // Register and request widths
    localparam int REG_W = 32;
    localparam int EXT_PINS = 8;
    localparam int LEVELS = 8;
    localparam int PERIPH_LINES = 8;
    localparam int SLOT_W = 2;
    localparam int SLOTS = 4;
    localparam int CODE_W = 8;
    localparam int SRC_W = 4;

    // Regular pending layout: pin n at bit 2n, level n at bit 2n+1
    localparam int REG_SOURCES = 16;

    // Reset values
    localparam logic [REG_W-1:0] PEND_RST = 32'h0000_0000;
    localparam logic [REG_W-1:0] MASK_RST = 32'h0000_0000;
    localparam logic [EXT_PINS-1:0] EDGE_CFG_RST = 8'h00;
    localparam logic [CODE_W-1:0] CODE_NONE = 8'h00;

    // Code step: source n has branch offset 8n and code 4n (code = offset >> 1)
    localparam int CODE_SHIFT = 2;
    localparam int OFFSET_SHIFT = 3;

    // Upper byte of the vector register holds the code
    localparam int VEC_CODE_LSB = 24;

    // Mode of the controller
    typedef enum logic [0:0] {
        MODE_REGULAR = 1'b0,
        MODE_ENHANCED = 1'b1
    } irq_mode_t;

    // Software write strobes with their data, carried together
    typedef struct packed {
        logic pend_clr;
        logic [REG_W-1:0] pend_data;
        logic mask_wr;
        logic [REG_W-1:0] mask_data;
    } sw_write_t;

    // Priority-encoder result
    typedef struct packed {
        logic hit;
        logic [5:0] index;
    } prio_t;

endpackage

// [irq_prio_enc.sv]
// Priority encoder: lowest set bit of a 32-bit request vector wins.
// Assumes the caller has already applied the masks; purely combinational.
`timescale 1ns/1ps
module irq_prio_enc (
    // Masked requests
    input wire logic [irq_ctrl_pkg::REG_W-1:0] req_i,
    // Winner
    output irq_ctrl_pkg::prio_t win_o
);
    import irq_ctrl_pkg::*;

    // Scan from the top so the lowest index is the last to overwrite
    always_comb begin
        win_o = '0;
        for (int i = REG_W - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                win_o.hit = 1'b1;
                win_o.index = 6'(i);
            end
        end
    end
endmodule

// [sys_irq_ctrl.sv]
// System interrupt controller: pending, mask, edge/level config, regular and
// enhanced modes, priority coding into the vector register.
// Assumes pins are asynchronous, internal sources and software strobes are
// synchronous to MCLK_I, and the peripheral bus lines are time-multiplexed
// with an externally supplied slot number.
`timescale 1ns/1ps

// What this block does
// - Each source has a fixed branch offset and code, code index times four.
// - The selected request's code sits in vector register bits 31 to 24.
// - Regular mode: any asserted pin or internal request sets its pending bit.
// - Cleared regular mask bit keeps that pending bit out of selection.
// - Enhanced mode turns on when the enhanced-controller enable bit is set.
// - Enhanced mode latches 32 peripheral levels over multiplexed interrupt lines.
// - Enhanced mode still takes pin and timer requests as in regular mode.
// - In enhanced mode the bus interface does not drive upper level lines.
// - Enhanced requests set bits in two pending registers, each maskable.
// - Highest priority pending unmasked request produces the vector code.
// - Enhanced mode may give offset zero after a clear with interrupts on.
// - Enhanced registers serve enhanced mode only; regular ones serve regular.
// - Each pending register is 32 bits, one bit per request.
// - Internal pending bits mirror their source; writes are ignored.
// - Level-sensitive pin bit follows the pin and cannot be written.
// - Edge-sensitive pin bit sets on falling edge, cleared by writing one.
// - Edge-level configuration selects each pin's sensitivity.
module sys_irq_ctrl (
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    // External request pins, active low, asynchronous
    input wire logic [irq_ctrl_pkg::EXT_PINS-1:0] EXT_REQUEST_PIN_N_I,
    // Internal level requests, active high, synchronous
    input wire logic [irq_ctrl_pkg::LEVELS-1:0] LEVEL_REQUEST_I,
    // Peripheral bus level lines and their time slot
    input wire logic [irq_ctrl_pkg::PERIPH_LINES-1:0] PERIPH_BUS_LEVEL_REQUEST_I,
    input wire logic [irq_ctrl_pkg::SLOT_W-1:0] PERIPH_SLOT_I,
    input wire logic PERIPH_SLOT_VALID_I,
    // Configuration
    input wire logic ENHANCED_CTRL_ENABLE_I,
    input wire logic EDGE_CFG_WR_I,
    input wire logic [irq_ctrl_pkg::EXT_PINS-1:0] EDGE_CFG_DATA_I,
    // Software writes to regular and enhanced registers
    input irq_ctrl_pkg::sw_write_t REGULAR_WR_I,
    input irq_ctrl_pkg::sw_write_t ENHANCED_A_WR_I,
    input irq_ctrl_pkg::sw_write_t ENHANCED_B_WR_I,
    // Register views
    output logic [irq_ctrl_pkg::REG_W-1:0] REGULAR_PENDING_O,
    output logic [irq_ctrl_pkg::REG_W-1:0] REGULAR_MASK_O,
    output logic [irq_ctrl_pkg::REG_W-1:0] ENHANCED_PENDING_A_O,
    output logic [irq_ctrl_pkg::REG_W-1:0] ENHANCED_PENDING_B_O,
    output logic [irq_ctrl_pkg::REG_W-1:0] ENHANCED_MASK_A_O,
    output logic [irq_ctrl_pkg::REG_W-1:0] ENHANCED_MASK_B_O,
    output logic [irq_ctrl_pkg::REG_W-1:0] ENHANCED_STATUS_A_O,
    output logic [irq_ctrl_pkg::REG_W-1:0] ENHANCED_STATUS_B_O,
    output logic [irq_ctrl_pkg::EXT_PINS-1:0] EDGE_LEVEL_CONFIG_O,
    output logic [irq_ctrl_pkg::REG_W-1:0] VECTOR_CODE_O,
    // Upper bus level drive permission for the bus interface, and core request
    output logic PERIPH_UPPER_DRIVE_EN_O,
    output logic CORE_IRQ_O
);
    import irq_ctrl_pkg::*;

    logic [EXT_PINS-1:0] pin_s1_reg;
    logic [EXT_PINS-1:0] pin_s2_reg;
    logic [EXT_PINS-1:0] pin_s3_reg;
    logic [EXT_PINS-1:0] pin_level_reg;
    logic [EXT_PINS-1:0] pin_fall;
    logic [EXT_PINS-1:0] edge_cfg_reg;
    logic [EXT_PINS-1:0] edge_pend_reg;
    logic [REG_W-1:0] periph_lat_reg;
    logic [REG_W-1:0] reg_pend_reg;
    logic [REG_W-1:0] reg_pend_next;
    logic [REG_W-1:0] reg_mask_reg;
    logic [REG_W-1:0] enh_a_pend_reg;
    logic [REG_W-1:0] enh_a_pend_next;
    logic [REG_W-1:0] enh_b_pend_reg;
    logic [REG_W-1:0] enh_b_mask_reg;
    logic [REG_W-1:0] enh_a_mask_reg;
    logic [REG_W-1:0] active_req;
    logic [REG_W-1:0] vector_reg;
    logic [REG_W-1:0] status_a_reg;
    logic [REG_W-1:0] status_b_reg;
    irq_mode_t mode_reg;
    logic core_irq_reg;
    logic upper_drive_reg;
    prio_t win;

    // Mode select is a plain register of the enable bit
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            mode_reg <= MODE_REGULAR;
        end else begin
            mode_reg <= ENHANCED_CTRL_ENABLE_I ? MODE_ENHANCED : MODE_REGULAR;
        end
    end

    // Three-stage pin synchroniser; a change counts when stages two and three agree
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            pin_s1_reg <= '1;
            pin_s2_reg <= '1;
            pin_s3_reg <= '1;
            pin_level_reg <= '1;
        end else begin
            pin_s1_reg <= EXT_REQUEST_PIN_N_I;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            for (int i = 0; i < EXT_PINS; i++) begin
                if (pin_s2_reg[i] == pin_s3_reg[i]) begin
                    pin_level_reg[i] <= pin_s3_reg[i];
                end
            end
        end
    end

    // Falling edge on the filtered level
    always_comb begin
        pin_fall = '0;
        for (int i = 0; i < EXT_PINS; i++) begin
            pin_fall[i] = pin_level_reg[i] && (pin_s2_reg[i] == pin_s3_reg[i]) && !pin_s3_reg[i];
        end
    end

    // Edge-level configuration, one bit per pin, 1 = edge
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            edge_cfg_reg <= EDGE_CFG_RST;
        end else if (EDGE_CFG_WR_I) begin
            edge_cfg_reg <= EDGE_CFG_DATA_I;
        end
    end

    // Edge latches shared by both modes; set beats a write-one clear
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            edge_pend_reg <= '0;
        end else begin
            for (int i = 0; i < EXT_PINS; i++) begin
                if (!edge_cfg_reg[i]) begin
                    edge_pend_reg[i] <= 1'b0;
                end else if (pin_fall[i]) begin
                    edge_pend_reg[i] <= 1'b1;
                end else if ((mode_reg == MODE_REGULAR && REGULAR_WR_I.pend_clr
                              && REGULAR_WR_I.pend_data[2*i])
                             || (mode_reg == MODE_ENHANCED && ENHANCED_A_WR_I.pend_clr
                              && ENHANCED_A_WR_I.pend_data[2*i])) begin
                    edge_pend_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Peripheral levels arrive four slots of eight lines; latch each slot as it comes
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            periph_lat_reg <= PEND_RST;
        end else if (mode_reg == MODE_ENHANCED && PERIPH_SLOT_VALID_I) begin
            for (int s = 0; s < SLOTS; s++) begin
                if (PERIPH_SLOT_I == SLOT_W'(s)) begin
                    periph_lat_reg[s*PERIPH_LINES +: PERIPH_LINES] <= PERIPH_BUS_LEVEL_REQUEST_I;
                end
            end
        end
    end

    // Pin and level pending image: pins on even bits, levels on odd bits
    always_comb begin
        reg_pend_next = PEND_RST;
        for (int i = 0; i < EXT_PINS; i++) begin
            reg_pend_next[2*i] = edge_cfg_reg[i] ? edge_pend_reg[i] : !pin_level_reg[i];
            reg_pend_next[2*i+1] = LEVEL_REQUEST_I[i];
        end
    end
    // Enhanced A reuses the same pin/timer layout, B holds peripheral levels
    assign enh_a_pend_next = reg_pend_next;

    // Pending registers track their sources; software writes only clear edges
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            reg_pend_reg <= PEND_RST;
            enh_a_pend_reg <= PEND_RST;
            enh_b_pend_reg <= PEND_RST;
        end else if (mode_reg == MODE_REGULAR) begin
            reg_pend_reg <= reg_pend_next;
            enh_a_pend_reg <= PEND_RST;
            enh_b_pend_reg <= PEND_RST;
        end else begin
            reg_pend_reg <= PEND_RST;
            enh_a_pend_reg <= enh_a_pend_next;
            enh_b_pend_reg <= periph_lat_reg;
        end
    end

    // Mask registers, written whole by software
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            reg_mask_reg <= MASK_RST;
            enh_a_mask_reg <= MASK_RST;
            enh_b_mask_reg <= MASK_RST;
        end else begin
            if (REGULAR_WR_I.mask_wr) begin
                reg_mask_reg <= REGULAR_WR_I.mask_data;
            end
            if (ENHANCED_A_WR_I.mask_wr) begin
                enh_a_mask_reg <= ENHANCED_A_WR_I.mask_data;
            end
            if (ENHANCED_B_WR_I.mask_wr) begin
                enh_b_mask_reg <= ENHANCED_B_WR_I.mask_data;
            end
        end
    end

    // Masked requests of the active mode; B only competes when A is empty
    always_comb begin
        if (mode_reg == MODE_REGULAR) begin
            active_req = reg_pend_reg & reg_mask_reg;
        end else if ((enh_a_pend_reg & enh_a_mask_reg) != '0) begin
            active_req = enh_a_pend_reg & enh_a_mask_reg;
        end else begin
            active_req = enh_b_pend_reg & enh_b_mask_reg;
        end
    end

    irq_prio_enc u_prio (
        .req_i(active_req),
        .win_o(win)
    );

    // Vector code and core request. With nothing left the code drops
    // to zero, which software reads as a spurious entry.
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            vector_reg <= PEND_RST;
            core_irq_reg <= 1'b0;
        end else begin
            vector_reg <= PEND_RST;
            if (win.hit) begin
                // Index n gives offset 8n and code 4n
                vector_reg[VEC_CODE_LSB +: CODE_W] <=
                    CODE_W'({2'b00, win.index} << CODE_SHIFT);
            end else begin
                vector_reg[VEC_CODE_LSB +: CODE_W] <= CODE_NONE;
            end
            core_irq_reg <= win.hit;
        end
    end

    // Enhanced status: pending and unmasked; upper-line permission off in enhanced
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            status_a_reg <= PEND_RST;
            status_b_reg <= PEND_RST;
            upper_drive_reg <= 1'b1;
        end else begin
            status_a_reg <= enh_a_pend_reg & enh_a_mask_reg;
            status_b_reg <= enh_b_pend_reg & enh_b_mask_reg;
            upper_drive_reg <= (mode_reg == MODE_REGULAR);
        end
    end

    // Outputs straight from flip-flops
    assign REGULAR_PENDING_O = reg_pend_reg;
    assign REGULAR_MASK_O = reg_mask_reg;
    assign ENHANCED_PENDING_A_O = enh_a_pend_reg;
    assign ENHANCED_PENDING_B_O = enh_b_pend_reg;
    assign ENHANCED_MASK_A_O = enh_a_mask_reg;
    assign ENHANCED_MASK_B_O = enh_b_mask_reg;
    assign ENHANCED_STATUS_A_O = status_a_reg;
    assign ENHANCED_STATUS_B_O = status_b_reg;
    assign EDGE_LEVEL_CONFIG_O = edge_cfg_reg;
    assign VECTOR_CODE_O = vector_reg;
    assign PERIPH_UPPER_DRIVE_EN_O = upper_drive_reg;
    assign CORE_IRQ_O = core_irq_reg;
endmodule

// [irq_periph_model.sv]
// Peripheral bus interface model: 32 levels over 8 lines, one slot a beat, or one every three beats when slow.
// Assumes slot s carries levels 8s..8s+7 and the block samples on valid.
`timescale 1ns/1ps
module irq_periph_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Control and levels
    input wire logic slow_i,
    input wire logic upper_drive_i,
    input wire logic [31:0] levels_i,
    // Multiplexed lines
    output logic [7:0] lines_o,
    output logic [1:0] slot_o,
    output logic valid_o
);
    logic [1:0] slot_reg;
    logic [1:0] gap_reg;
    // Idle beats drop valid and invert the lines, so stale data cannot pass as valid
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            slot_reg <= 2'h0;
            gap_reg <= 2'h0;
            valid_o <= 1'h0;
            lines_o <= 8'h00;
            slot_o <= 2'h0;
        end else if (upper_drive_i || gap_reg != 2'h0) begin
            gap_reg <= gap_reg >> 1;
            valid_o <= 1'h0;
            lines_o <= ~lines_o;
        end else begin
            valid_o <= 1'h1;
            lines_o <= levels_i[8 * slot_reg +: 8];
            slot_o <= slot_reg;
            slot_reg <= slot_reg + 2'h1;
            gap_reg <= {2{slow_i}};
        end
    end
endmodule

// [irq_ctrl_checker.sv]
// Checker for the interrupt controller, bound to its top ports.
// Assumes results are judged once the mode input has stood still a while.
`timescale 1ns/1ps
module irq_ctrl_checker (
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    // Inputs
    input wire logic ENHANCED_CTRL_ENABLE_I,
    input wire logic EDGE_CFG_WR_I,
    input wire logic [7:0] EDGE_CFG_DATA_I,
    // Outputs
    input wire logic [31:0] REGULAR_PENDING_O,
    input wire logic [31:0] REGULAR_MASK_O,
    input wire logic [31:0] ENHANCED_PENDING_A_O,
    input wire logic [31:0] ENHANCED_PENDING_B_O,
    input wire logic [31:0] ENHANCED_MASK_A_O,
    input wire logic [31:0] ENHANCED_MASK_B_O,
    input wire logic [7:0] EDGE_LEVEL_CONFIG_O,
    input wire logic [31:0] VECTOR_CODE_O,
    input wire logic PERIPH_UPPER_DRIVE_EN_O,
    input wire logic CORE_IRQ_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RESETN_I);
    logic [31:0] ab_req;
    logic any_req;
    // Inactive mode reads zero, so both modes may be OR-ed
    assign ab_req = (REGULAR_PENDING_O & REGULAR_MASK_O) | (ENHANCED_PENDING_A_O & ENHANCED_MASK_A_O);
    assign any_req = (|ab_req) || (|(ENHANCED_PENDING_B_O & ENHANCED_MASK_B_O));
    sequence s_settled;
        $stable(ENHANCED_CTRL_ENABLE_I) [*4];
    endsequence
    property p_vec_low;
        VECTOR_CODE_O[23:0] == 24'h00_0000;
    endproperty
    a_vec_low: assert property (p_vec_low) else $error("vector low bits set");
    property p_core_irq;
        s_settled ##0 any_req |=> CORE_IRQ_O;
    endproperty
    a_core_irq: assert property (p_core_irq) else $error("core request missing");
    property p_idle;
        s_settled ##0 !any_req |=> !CORE_IRQ_O && VECTOR_CODE_O == 32'h0000_0000;
    endproperty
    a_idle: assert property (p_idle) else $error("request without unmasked bit");
    // Winner bit set and nothing below it
    property p_code;
        s_settled ##0 (|ab_req) |=> VECTOR_CODE_O[25:24] == 2'h0
            && (($past(ab_req) >> VECTOR_CODE_O[30:26]) & 32'h0000_0001) == 32'h0000_0001
            && !VECTOR_CODE_O[31]
            && ($past(ab_req) & ((32'h0000_0001 << VECTOR_CODE_O[30:26]) - 1)) == 0;
    endproperty
    a_code: assert property (p_code) else $error("wrong vector code");
    property p_mode;
        $stable(ENHANCED_CTRL_ENABLE_I) [*3] |=> PERIPH_UPPER_DRIVE_EN_O == !$past(ENHANCED_CTRL_ENABLE_I);
    endproperty
    a_mode: assert property (p_mode) else $error("upper drive wrong");
    property p_inactive;
        s_settled |-> (ENHANCED_CTRL_ENABLE_I ? REGULAR_PENDING_O
            : (ENHANCED_PENDING_A_O | ENHANCED_PENDING_B_O)) == 32'h0000_0000;
    endproperty
    a_inactive: assert property (p_inactive) else $error("inactive pending set");
    property p_width;
        (REGULAR_PENDING_O[31:16] | ENHANCED_PENDING_A_O[31:16]) == 16'h0000;
    endproperty
    a_width: assert property (p_width) else $error("unused pending bit set");
    property p_cfg;
        EDGE_CFG_WR_I |=> EDGE_LEVEL_CONFIG_O == $past(EDGE_CFG_DATA_I);
    endproperty
    a_cfg: assert property (p_cfg) else $error("edge config not taken");
endmodule

bind sys_irq_ctrl irq_ctrl_checker u_chk (.MCLK_I, .RESETN_I, .ENHANCED_CTRL_ENABLE_I,
    .EDGE_CFG_WR_I, .EDGE_CFG_DATA_I, .REGULAR_PENDING_O, .REGULAR_MASK_O,
    .ENHANCED_PENDING_A_O, .ENHANCED_PENDING_B_O, .ENHANCED_MASK_A_O, .ENHANCED_MASK_B_O,
    .EDGE_LEVEL_CONFIG_O, .VECTOR_CODE_O, .PERIPH_UPPER_DRIVE_EN_O, .CORE_IRQ_O);

// [sys_irq_ctrl_tb.sv]
// Testbench for the interrupt controller with a peripheral bus model.
// Assumes the checker is bound in; the bench acts as software.
`timescale 1ns/1ps
module sys_irq_ctrl_tb;
    import irq_ctrl_pkg::*;
    logic MCLK_I = 1'h0, RESETN_I = 1'h0, ENHANCED_CTRL_ENABLE_I = 1'h0;
    logic EDGE_CFG_WR_I = 1'h0, slow = 1'h0, PERIPH_SLOT_VALID_I, PERIPH_UPPER_DRIVE_EN_O, CORE_IRQ_O;
    logic [7:0] EXT_REQUEST_PIN_N_I = 8'hFF, LEVEL_REQUEST_I = 8'h00, EDGE_CFG_DATA_I = 8'h00;
    logic [7:0] PERIPH_BUS_LEVEL_REQUEST_I, EDGE_LEVEL_CONFIG_O;
    logic [1:0] PERIPH_SLOT_I;
    logic [31:0] levels = 32'h0000_0000, VECTOR_CODE_O, REGULAR_PENDING_O, REGULAR_MASK_O;
    logic [31:0] ENHANCED_PENDING_A_O, ENHANCED_PENDING_B_O, ENHANCED_MASK_A_O, ENHANCED_MASK_B_O;
    logic [31:0] ENHANCED_STATUS_A_O, ENHANCED_STATUS_B_O;
    sw_write_t REGULAR_WR_I = '0, ENHANCED_A_WR_I = '0, ENHANCED_B_WR_I = '0;
    int miscompares = 0, checked = 0, cycles = 0;

    sys_irq_ctrl uut (.MCLK_I, .RESETN_I, .EXT_REQUEST_PIN_N_I, .LEVEL_REQUEST_I,
        .PERIPH_BUS_LEVEL_REQUEST_I, .PERIPH_SLOT_I, .PERIPH_SLOT_VALID_I, .ENHANCED_CTRL_ENABLE_I,
        .EDGE_CFG_WR_I, .EDGE_CFG_DATA_I, .REGULAR_WR_I, .ENHANCED_A_WR_I, .ENHANCED_B_WR_I,
        .REGULAR_PENDING_O, .REGULAR_MASK_O, .ENHANCED_PENDING_A_O, .ENHANCED_PENDING_B_O,
        .ENHANCED_MASK_A_O, .ENHANCED_MASK_B_O, .ENHANCED_STATUS_A_O, .ENHANCED_STATUS_B_O,
        .EDGE_LEVEL_CONFIG_O, .VECTOR_CODE_O, .PERIPH_UPPER_DRIVE_EN_O, .CORE_IRQ_O);
    irq_periph_model u_periph (.clk_i(MCLK_I), .rstn_i(RESETN_I), .slow_i(slow),
        .upper_drive_i(PERIPH_UPPER_DRIVE_EN_O), .levels_i(levels),
        .lines_o(PERIPH_BUS_LEVEL_REQUEST_I), .slot_o(PERIPH_SLOT_I), .valid_o(PERIPH_SLOT_VALID_I));

    // Clock and hang guard
    always #50 MCLK_I = ~MCLK_I;
    always @(posedge MCLK_I) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            conclude();
        end
    end

    // One bit wider than a register so a flag can ride above a full word
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Settle just past the edge so sampled outputs are stable
    task automatic go(input int n);
        repeat (n) @(posedge MCLK_I);
        #1;
    endtask
    // One-cycle write: pend clear with data, or mask write
    task automatic wr(input int w, input logic clr, input logic [31:0] d);
        sw_write_t s;
        s = clr ? sw_write_t'{1'h1, d, 1'h0, 32'h0000_0000}
                : sw_write_t'{1'h0, 32'h0000_0000, 1'h1, d};
        @(posedge MCLK_I);
        REGULAR_WR_I <= (w == 0) ? s : '0;
        ENHANCED_A_WR_I <= (w == 1) ? s : '0;
        ENHANCED_B_WR_I <= (w == 2) ? s : '0;
        @(posedge MCLK_I) {REGULAR_WR_I, ENHANCED_A_WR_I, ENHANCED_B_WR_I} <= '0;
        go(2);
    endtask
    // Pin 4 low for three cycles
    task automatic fall();
        @(posedge MCLK_I) EXT_REQUEST_PIN_N_I <= 8'hEF;
        repeat (3) @(posedge MCLK_I);
        EXT_REQUEST_PIN_N_I <= 8'hFF;
        go(8);
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        go(7);
        @(posedge MCLK_I) RESETN_I <= 1'h1;
        go(2);
        chk(REGULAR_PENDING_O | ENHANCED_PENDING_A_O | ENHANCED_PENDING_B_O | VECTOR_CODE_O, 0);
        chk(REGULAR_MASK_O | ENHANCED_MASK_A_O | ENHANCED_MASK_B_O, 0);
        chk({PERIPH_UPPER_DRIVE_EN_O, CORE_IRQ_O}, 32'h0000_0002);
        $display("Test reset done");
        // Internal levels 7 then 4, write ignored, mask removes one
        wr(0, 1'h0, 32'hFFFF_FFFF);
        @(posedge MCLK_I) LEVEL_REQUEST_I <= 8'h80;
        go(3);
        chk(REGULAR_PENDING_O, 32'h0000_8000);
        chk(VECTOR_CODE_O | 32'(CORE_IRQ_O), 32'h3C00_0001);
        @(posedge MCLK_I) LEVEL_REQUEST_I <= 8'h90;
        go(3);
        chk(VECTOR_CODE_O, 32'h2400_0000);
        wr(0, 1'h1, 32'hFFFF_FFFF);
        chk(REGULAR_PENDING_O, 32'h0000_8200);
        wr(0, 1'h0, 32'hFFFF_FDFF);
        chk(VECTOR_CODE_O, 32'h3C00_0000);
        @(posedge MCLK_I) LEVEL_REQUEST_I <= 8'h00;
        go(3);
        chk(VECTOR_CODE_O | 32'(CORE_IRQ_O) | REGULAR_PENDING_O, 0);
        $display("Test levels done");
        // Level-sensitive pin 4
        @(posedge MCLK_I) EXT_REQUEST_PIN_N_I <= 8'hEF;
        go(8);
        chk(VECTOR_CODE_O, 32'h2000_0000);
        wr(0, 1'h1, 32'h0000_0100);
        chk(REGULAR_PENDING_O, 32'h0000_0100);
        @(posedge MCLK_I) EXT_REQUEST_PIN_N_I <= 8'hFF;
        go(8);
        chk(REGULAR_PENDING_O, 0);
        // Edge-sensitive pin 4
        @(posedge MCLK_I) {EDGE_CFG_WR_I, EDGE_CFG_DATA_I} <= {1'h1, 8'h10};
        @(posedge MCLK_I) EDGE_CFG_WR_I <= 1'h0;
        go(1);
        chk(EDGE_LEVEL_CONFIG_O, 32'h0000_0010);
        fall();
        chk(REGULAR_PENDING_O, 32'h0000_0100);
        wr(0, 1'h1, 32'h0000_0100);
        chk(REGULAR_PENDING_O, 0);
        $display("Test pins done");
        // Enhanced mode with prompt peripheral slots
        @(posedge MCLK_I) ENHANCED_CTRL_ENABLE_I <= 1'h1;
        go(4);
        chk({PERIPH_UPPER_DRIVE_EN_O, REGULAR_PENDING_O}, 0);
        wr(1, 1'h0, 32'hFFFF_FFFF);
        wr(2, 1'h0, 32'hFFFF_FFFF);
        @(posedge MCLK_I) {levels, LEVEL_REQUEST_I} <= {32'h0001_0000, 8'h80};
        go(12);
        chk(ENHANCED_PENDING_B_O, 32'h0001_0000);
        chk(ENHANCED_PENDING_A_O, 32'h0000_8000);
        chk(VECTOR_CODE_O, 32'h3C00_0000);
        chk(ENHANCED_STATUS_A_O, 32'h0000_8000);
        chk(ENHANCED_STATUS_B_O, 32'h0001_0000);
        wr(1, 1'h0, 32'h0000_0000);
        chk(VECTOR_CODE_O | 32'(CORE_IRQ_O), 32'h4000_0001);
        wr(2, 1'h0, 32'h0000_0000);
        chk(VECTOR_CODE_O | 32'(CORE_IRQ_O), 0);
        wr(1, 1'h0, 32'hFFFF_FFFF);
        fall();
        chk(ENHANCED_PENDING_A_O, 32'h0000_8100);
        // Clear the pin 4 edge bit in A, then read level 31 back over slow slots
        wr(1, 1'h1, 32'h0000_0100);
        chk(ENHANCED_PENDING_A_O, 32'h0000_8000);
        @(posedge MCLK_I) {slow, levels} <= {1'h1, 32'h8000_0000};
        go(20);
        chk(ENHANCED_PENDING_B_O, 32'h8000_0000);
        $display("Test enhanced done");
        // Back to regular mode
        @(posedge MCLK_I) ENHANCED_CTRL_ENABLE_I <= 1'h0;
        go(4);
        chk(ENHANCED_PENDING_A_O | ENHANCED_PENDING_B_O, 0);
        chk({PERIPH_UPPER_DRIVE_EN_O, REGULAR_PENDING_O}, 33'h1_0000_8000);
        $display("Test return done");
        conclude();
    end
endmodule
